// ==== shared/bus_area_pkg.sv ====
package bus_area_pkg;
  // ****************
  // register map
  // ****************
  localparam logic [3:0] BUS_CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] MODE_STATUS_OFFSET = 4'h4;
  // ****************
  // bus_control fields
  // ****************
  localparam int AREA_CTRL_ENABLE_BIT = 7;
  localparam int ZERO_PAGE_SLOW_BIT = 6;
  localparam int RESERVED_BIT = 5;
  localparam int PORTS_NINE_A_ENABLE_BIT = 4;
  localparam int OFFCHIP_PORT_SELECT_BIT = 3;
  localparam int PULLUP_REGS_ENABLE_BIT = 2;
  localparam int PORTS_B_C_ENABLE_BIT = 1;
  localparam int PORTS_ONE_TWO_ENABLE_BIT = 0;
  localparam logic [7:0] BUS_CONTROL_RESET = 8'h3F;
  localparam logic [4:0] REMAP_BITS_MASK = 5'h1F;
  // ****************
  // operating modes
  // ****************
  localparam logic [2:0] MODE_FIXED_NARROW = 3'h2;
  localparam logic [2:0] MODE_SOFT_ENABLE_A = 3'h5;
  localparam logic [2:0] MODE_SOFT_ENABLE_B = 3'h6;
  localparam logic [2:0] MODE_SINGLE_CHIP = 3'h7;
  localparam logic [2:0] MODE_RESET = 3'h7;
  // ****************
  // port windows (upper 18 address bits, 4-byte granules)
  // ****************
  localparam logic [17:0] PORTS_ONE_TWO_BASE = 18'h03FA0;
  localparam logic [17:0] PORTS_NINE_A_BASE = 18'h03FA4;
  localparam logic [17:0] PORTS_B_C_BASE = 18'h03FA5;
  localparam logic [17:0] PULLUP_REGS_BASE = 18'h03FA6;
  localparam logic [17:0] OFFCHIP_PORT_BASE = 18'h03FA7;
  // ****************
  // axi answers
  // ****************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verilog/bus_area_port_enable_control.sv ====
`timescale 1ns/1ps
// Contract
// - zero-page bit forces page 0 three-state
// - single-chip mode ignores zero-page bit
// - bit 5 reads one, ignores writes
// - ports 9/A disabled go external byte
// - ports 9/A enabled respond on-chip
// - offchip port select zero maps external
// - offchip port select one leaves unreachable
// - pull-up regs disabled go external byte
// - pull-up regs enabled respond on-chip
// - ports B/C disabled go external byte
// - ports B/C enabled respond on-chip
// - ports 1/2 disabled go external byte
// - ports 1/2 enabled respond on-chip
// - single-chip mode refuses clearing remap bits
// - byte cycles use upper data lanes
// - area enable zero forces byte three-state
module bus_area_port_enable_control (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [2:0] mode_pins_i,
  input wire logic [7:0] width_boundary_i,
  input wire logic [7:0] slow_boundary_i,
  input wire logic cpu_req_i,
  input wire logic [19:0] cpu_addr_i,
  input wire logic cpu_ext_space_i,
  output logic dec_valid_o,
  output logic onchip_port_o,
  output logic ext_cycle_o,
  output logic ext_byte_o,
  output logic ext_slow_o,
  output logic upper_lane_o,
  output logic unreach_o
);

  // ****************
  // mode pin synchroniser
  // ****************
  logic [2:0] mode_meta_q;
  logic [2:0] mode_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_meta_q <= bus_area_pkg::MODE_RESET;
      mode_q <= bus_area_pkg::MODE_RESET;
    end else begin
      mode_meta_q <= mode_pins_i;
      mode_q <= mode_meta_q;
    end
  end

  logic single_chip;
  logic soft_enable_mode;
  assign single_chip = (mode_q == bus_area_pkg::MODE_SINGLE_CHIP);
  assign soft_enable_mode = (mode_q == bus_area_pkg::MODE_SOFT_ENABLE_A) ||
                            (mode_q == bus_area_pkg::MODE_SOFT_ENABLE_B);

  // ****************
  // axi write channel
  // ****************
  logic aw_held_q;
  logic [3:0] aw_addr_q;
  logic w_held_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic do_write;

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid_o;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_held_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= bus_area_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata_i[7:0];
        w_lane_q <= s_axi_wstrb_i[0];
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (aw_addr_q == bus_area_pkg::BUS_CONTROL_OFFSET ||
                          aw_addr_q == bus_area_pkg::MODE_STATUS_OFFSET) ?
                         bus_area_pkg::RESP_OKAY : bus_area_pkg::RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ****************
  // axi write ready flags
  // ****************
  // low while the channel is held or a response is pending
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        s_axi_wready_o <= 1'b0;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // ****************
  // bus_control register
  // ****************
  logic area_enable_bit_q;
  logic zero_page_slow_q;
  logic [4:0] remap_q;
  logic ctrl_write;
  logic area_ctrl_enable;
  logic [7:0] bus_control_rd;

  assign ctrl_write = do_write && w_lane_q && (aw_addr_q == bus_area_pkg::BUS_CONTROL_OFFSET);
  // area enable is fixed at one outside the two soft-enable modes
  assign area_ctrl_enable = area_enable_bit_q || !soft_enable_mode;
  assign bus_control_rd = {area_ctrl_enable, zero_page_slow_q, 1'b1, remap_q};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      area_enable_bit_q <= bus_area_pkg::BUS_CONTROL_RESET[bus_area_pkg::AREA_CTRL_ENABLE_BIT];
      zero_page_slow_q <= bus_area_pkg::BUS_CONTROL_RESET[bus_area_pkg::ZERO_PAGE_SLOW_BIT];
      remap_q <= bus_area_pkg::BUS_CONTROL_RESET[4:0];
    end else if (ctrl_write) begin
      area_enable_bit_q <= w_data_q[bus_area_pkg::AREA_CTRL_ENABLE_BIT];
      zero_page_slow_q <= w_data_q[bus_area_pkg::ZERO_PAGE_SLOW_BIT];
      remap_q <= single_chip ? (w_data_q[4:0] | bus_area_pkg::REMAP_BITS_MASK) : w_data_q[4:0];
    end
  end

  // ****************
  // axi read channel
  // ****************
  // low while a read answer is pending
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b1;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= bus_area_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= bus_area_pkg::RESP_OKAY;
      unique case (s_axi_araddr_i)
        bus_area_pkg::BUS_CONTROL_OFFSET: s_axi_rdata_o <= {24'h00_0000, bus_control_rd};
        bus_area_pkg::MODE_STATUS_OFFSET: s_axi_rdata_o <= {29'h0000_0000, mode_q};
        default: begin
          s_axi_rdata_o <= 32'h0000_0000;
          s_axi_rresp_o <= bus_area_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ****************
  // cpu access decode
  // ****************
  logic [17:0] granule;
  logic hit_p12;
  logic hit_p9a;
  logic hit_pbc;
  logic hit_pcr;
  logic hit_offchip;
  logic port_enabled;
  logic port_remapped;
  logic min_mode;
  logic [7:0] area_key;
  logic page_zero;
  logic ext_d;
  logic byte_d;
  logic slow_d;
  logic onchip_d;
  logic unreach_d;

  assign granule = cpu_addr_i[19:2];
  assign hit_p12 = (granule == bus_area_pkg::PORTS_ONE_TWO_BASE);
  assign hit_p9a = (granule == bus_area_pkg::PORTS_NINE_A_BASE);
  assign hit_pbc = (granule == bus_area_pkg::PORTS_B_C_BASE);
  assign hit_pcr = (granule == bus_area_pkg::PULLUP_REGS_BASE);
  assign hit_offchip = (granule == bus_area_pkg::OFFCHIP_PORT_BASE);
  assign min_mode = (mode_q == 3'h1) || (mode_q == 3'h2) || (mode_q == 3'h6);
  assign area_key = min_mode ? cpu_addr_i[15:8] : cpu_addr_i[19:12];
  assign page_zero = (cpu_addr_i[19:16] == 4'h0);

  always_comb begin
    port_enabled = 1'b0;
    port_remapped = 1'b0;
    if (hit_p12) begin
      port_enabled = remap_q[bus_area_pkg::PORTS_ONE_TWO_ENABLE_BIT];
      port_remapped = !remap_q[bus_area_pkg::PORTS_ONE_TWO_ENABLE_BIT];
    end else if (hit_p9a) begin
      port_enabled = remap_q[bus_area_pkg::PORTS_NINE_A_ENABLE_BIT];
      port_remapped = !remap_q[bus_area_pkg::PORTS_NINE_A_ENABLE_BIT];
    end else if (hit_pbc) begin
      port_enabled = remap_q[bus_area_pkg::PORTS_B_C_ENABLE_BIT];
      port_remapped = !remap_q[bus_area_pkg::PORTS_B_C_ENABLE_BIT];
    end else if (hit_pcr) begin
      port_enabled = remap_q[bus_area_pkg::PULLUP_REGS_ENABLE_BIT];
      port_remapped = !remap_q[bus_area_pkg::PULLUP_REGS_ENABLE_BIT];
    end else if (hit_offchip) begin
      port_remapped = !remap_q[bus_area_pkg::OFFCHIP_PORT_SELECT_BIT];
    end
  end

  always_comb begin
    onchip_d = port_enabled;
    unreach_d = hit_offchip && !port_remapped;
    ext_d = 1'b0;
    byte_d = 1'b0;
    slow_d = 1'b0;
    if (port_remapped) begin
      ext_d = 1'b1;
      byte_d = 1'b1;
      slow_d = 1'b1;
    end else if (cpu_ext_space_i && !single_chip && !onchip_d && !unreach_d) begin
      ext_d = 1'b1;
      if (!area_ctrl_enable || mode_q == bus_area_pkg::MODE_FIXED_NARROW) begin
        byte_d = 1'b1;
        slow_d = 1'b1;
      end else begin
        byte_d = (area_key >= width_boundary_i);
        slow_d = (area_key >= slow_boundary_i) || (zero_page_slow_q && page_zero);
      end
    end
  end

  // decode uses the register as it stands after any earlier write
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dec_valid_o <= 1'b0;
      onchip_port_o <= 1'b0;
      ext_cycle_o <= 1'b0;
      ext_byte_o <= 1'b0;
      ext_slow_o <= 1'b0;
      upper_lane_o <= 1'b0;
      unreach_o <= 1'b0;
    end else begin
      dec_valid_o <= cpu_req_i;
      onchip_port_o <= cpu_req_i && onchip_d;
      ext_cycle_o <= cpu_req_i && ext_d;
      ext_byte_o <= cpu_req_i && ext_d && byte_d;
      ext_slow_o <= cpu_req_i && ext_d && slow_d;
      upper_lane_o <= cpu_req_i && ext_d && byte_d;
      unreach_o <= cpu_req_i && unreach_d;
    end
  end

  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_reserved_reads_one: assert property (bus_control_rd[bus_area_pkg::RESERVED_BIT])
    else $error("reserved bit not one");
  a_single_chip_keeps: assert property (single_chip && ctrl_write |=> remap_q == 5'h1F)
    else $error("remap bit cleared in single-chip mode");
  a_port12_remap: assert property (cpu_req_i && hit_p12 && !remap_q[0] |=> ext_cycle_o && ext_byte_o && ext_slow_o)
    else $error("ports 1/2 not remapped");
  a_port9a_onchip: assert property (cpu_req_i && hit_p9a && remap_q[4] |=> onchip_port_o && !ext_cycle_o)
    else $error("ports 9/A not on-chip");
  a_offchip_blocked: assert property (cpu_req_i && hit_offchip && remap_q[3] |=> unreach_o && !ext_cycle_o)
    else $error("offchip range reachable");
  a_lane_upper: assert property (ext_byte_o |-> upper_lane_o)
    else $error("byte cycle not on upper lanes");
  a_area_off_byte: assert property (cpu_req_i && ext_d && !area_ctrl_enable |=> ext_byte_o && ext_slow_o)
    else $error("area disabled but not byte three-state");
  a_zero_page_slow: assert property (cpu_req_i && cpu_ext_space_i && !single_chip && page_zero && zero_page_slow_q
    && !hit_offchip && !(port_enabled || port_remapped) |=> ext_slow_o)
    else $error("page zero not three-state");
  a_single_no_ext: assert property (cpu_req_i && single_chip && !port_remapped |=> !ext_cycle_o)
    else $error("external cycle in single-chip mode");
  a_write_next_cycle: assert property (ctrl_write && !single_chip |=> remap_q == $past(w_data_q[4:0]))
    else $error("write not applied next cycle");
  a_port9a_remap: assert property (cpu_req_i && hit_p9a && !remap_q[bus_area_pkg::PORTS_NINE_A_ENABLE_BIT]
    |=> ext_cycle_o && ext_byte_o && ext_slow_o && !onchip_port_o)
    else $error("ports 9/A not remapped");
  a_offchip_open: assert property (cpu_req_i && hit_offchip && !remap_q[bus_area_pkg::OFFCHIP_PORT_SELECT_BIT]
    |=> ext_cycle_o && ext_byte_o && ext_slow_o && !unreach_o)
    else $error("offchip range not external");
  a_pullup_remap: assert property (cpu_req_i && hit_pcr && !remap_q[bus_area_pkg::PULLUP_REGS_ENABLE_BIT]
    |=> ext_cycle_o && ext_byte_o && ext_slow_o && !onchip_port_o)
    else $error("pull-up regs not remapped");
  a_pullup_onchip: assert property (cpu_req_i && hit_pcr && remap_q[bus_area_pkg::PULLUP_REGS_ENABLE_BIT]
    |=> onchip_port_o && !ext_cycle_o)
    else $error("pull-up regs not on-chip");
  a_portbc_remap: assert property (cpu_req_i && hit_pbc && !remap_q[bus_area_pkg::PORTS_B_C_ENABLE_BIT]
    |=> ext_cycle_o && ext_byte_o && ext_slow_o && !onchip_port_o)
    else $error("ports B/C not remapped");
  a_portbc_onchip: assert property (cpu_req_i && hit_pbc && remap_q[bus_area_pkg::PORTS_B_C_ENABLE_BIT]
    |=> onchip_port_o && !ext_cycle_o)
    else $error("ports B/C not on-chip");
  a_port12_onchip: assert property (cpu_req_i && hit_p12 && remap_q[bus_area_pkg::PORTS_ONE_TWO_ENABLE_BIT]
    |=> onchip_port_o && !ext_cycle_o)
    else $error("ports 1/2 not on-chip");

  c_port_remap: cover property (cpu_req_i && port_remapped ##1 ext_cycle_o);
  c_offchip_open: cover property (cpu_req_i && hit_offchip && !remap_q[3]);
  c_ctrl_write: cover property (ctrl_write ##1 s_axi_bvalid_o);
  c_zero_page: cover property (cpu_req_i && page_zero && zero_page_slow_q && ext_d ##1 ext_slow_o);
  c_single_write: cover property (single_chip && ctrl_write);

endmodule // bus_area_port_enable_control

// ==== verif/ext_bus_model.sv ====
`timescale 1ns/1ps
// ****************
// expansion bus side: counts byte cycles on the upper lanes
// ****************
module ext_bus_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic dec_valid_i,
  input wire logic ext_cycle_i,
  input wire logic upper_lane_i,
  output logic [7:0] ext_seen_o
);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) ext_seen_o <= 8'h00;
    else if (dec_valid_i && ext_cycle_i && upper_lane_i) ext_seen_o <= ext_seen_o + 8'h01;
  end
endmodule // ext_bus_model

// ==== verif/bus_area_port_enable_control_bench.sv ====
`timescale 1ns/1ps
module bus_area_port_enable_control_bench;
  // ****************
  // stimulus and wiring
  // ****************
  logic clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_d;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic cpu_req = 1'h0, ext_space = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, dv, onc, ext, byt, slw, upl, unr;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] mode = 3'h5;
  logic [19:0] caddr = 20'h0;
  logic [6:0] cls;
  logic [7:0] seen;
  logic [7:0] wb = 8'hFF, sb = 8'hFF;
  logic [19:0] base [5] = '{20'h0FE80, 20'h0FE90, 20'h0FE94, 20'h0FE98, 20'h0FE9C};
  int fails = 0, checks_done = 0;
  always #5 clk_i = ~clk_i;
  bus_area_port_enable_control i_bus_area_port_enable_control (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .mode_pins_i(mode), .width_boundary_i(wb), .slow_boundary_i(sb),
    .cpu_req_i(cpu_req), .cpu_addr_i(caddr), .cpu_ext_space_i(ext_space),
    .dec_valid_o(dv), .onchip_port_o(onc), .ext_cycle_o(ext), .ext_byte_o(byt),
    .ext_slow_o(slw), .upper_lane_o(upl), .unreach_o(unr));
  ext_bus_model i_ext_bus_model (.clk_i(clk_i), .resetn_i(resetn_i), .dec_valid_i(dv),
    .ext_cycle_i(ext), .upper_lane_i(upl), .ext_seen_o(seen));
  // ****************
  // shared tasks
  // ****************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ah, wh, done;
    done = 1'h0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done) begin
      @(negedge clk_i);
      ah = awvalid && awready;
      wh = wvalid && wready;
      done = bvalid;
      resp = bresp;
      @(posedge clk_i);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
      if (done) bready <= 1'h0;
    end
    check("write answered", 1'h1, done);
  endtask
  task automatic rd(input logic [3:0] a);
    logic ah, done;
    done = 1'h0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done) begin
      @(negedge clk_i);
      ah = arvalid && arready;
      done = rvalid;
      rd_d = rdata;
      resp = rresp;
      @(posedge clk_i);
      if (ah) arvalid <= 1'h0;
      if (done) rready <= 1'h0;
    end
    check("read answered", 1'h1, done);
  endtask
  task automatic dec(input logic [19:0] a, input logic sp);
    @(posedge clk_i);
    cpu_req <= 1'h1;
    caddr <= a;
    ext_space <= sp;
    @(posedge clk_i);
    cpu_req <= 1'h0;
    @(negedge clk_i);
    cls = {dv, onc, ext, byt, slw, upl, unr};
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    rd(bus_area_pkg::BUS_CONTROL_OFFSET);
    check("reset value", 32'h3F, rd_d);
    rd(bus_area_pkg::MODE_STATUS_OFFSET);
    check("mode status", 32'h5, rd_d);
  endtask
  task automatic t_ports();
    wr(bus_area_pkg::BUS_CONTROL_OFFSET, 8'h00);
    rd(bus_area_pkg::BUS_CONTROL_OFFSET);
    check("reserved bit", 32'h20, rd_d);
    for (int i = 0; i < 5; i++) begin
      dec(base[i], 1'h0);
      check("port low", 7'h5E, cls);
      dec(base[i] + 20'h3, 1'h0);
      check("port high", 7'h5E, cls);
    end
    @(negedge clk_i);
    check("far side count", 8'h0A, seen);
    wr(bus_area_pkg::BUS_CONTROL_OFFSET, 8'h1F);
    for (int i = 0; i < 4; i++) begin
      dec(base[i] + 20'h1, 1'h0);
      check("on chip", 7'h60, cls);
    end
    dec(base[4], 1'h0);
    check("offchip closed", 7'h41, cls);
  endtask
  task automatic t_zero_page();
    wr(bus_area_pkg::BUS_CONTROL_OFFSET, 8'hDF);
    dec(20'h01000, 1'h1);
    check("page 0 slow", 7'h54, cls);
    wr(bus_area_pkg::BUS_CONTROL_OFFSET, 8'h9F);
    dec(20'h01000, 1'h1);
    check("page 0 fast", 7'h50, cls);
    @(posedge clk_i);
    wb <= 8'h02;
    sb <= 8'h01;
    dec(20'h01000, 1'h1);
    check("slow boundary", 7'h54, cls);
    dec(20'h02000, 1'h1);
    check("width boundary", 7'h5E, cls);
    wr(bus_area_pkg::BUS_CONTROL_OFFSET, 8'h1F);
    dec(20'h01000, 1'h1);
    check("area off", 7'h5E, cls);
  endtask
  task automatic t_errors();
    wr(4'h8, 8'h00);
    check("write unmapped", bus_area_pkg::RESP_SLVERR, resp);
    rd(4'h8);
    check("read unmapped", bus_area_pkg::RESP_SLVERR, resp);
    check("unmapped data", 32'h0, rd_d);
    wr(bus_area_pkg::MODE_STATUS_OFFSET, 8'h00);
    check("write status", bus_area_pkg::RESP_OKAY, resp);
  endtask
  task automatic t_single_chip();
    @(posedge clk_i);
    mode <= bus_area_pkg::MODE_FIXED_NARROW;
    repeat (3) @(posedge clk_i);
    dec(20'h01000, 1'h1);
    check("narrow mode", 7'h5E, cls);
    @(posedge clk_i);
    mode <= bus_area_pkg::MODE_SINGLE_CHIP;
    repeat (3) @(posedge clk_i);
    wr(bus_area_pkg::BUS_CONTROL_OFFSET, 8'h40);
    rd(bus_area_pkg::BUS_CONTROL_OFFSET);
    check("remap kept", 32'hFF, rd_d);
    dec(20'h01000, 1'h1);
    check("no ext cycle", 1'h0, cls[4]);
    check("no slow", 1'h0, cls[2]);
  endtask
  // ****************
  // run control
  // ****************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_ports();
    t_zero_page();
    t_errors();
    t_single_chip();
    finish_test();
  end
endmodule // bus_area_port_enable_control_bench
